// [design/pin_select_pkg.sv]
// constants and carrier types for the status pin signal select block
package pin_select_pkg;

	// register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [3:0] OFS_PIN0_CFG  = 4'h0;
	localparam logic [3:0] OFS_PIN1_CFG  = 4'h1;
	localparam logic [3:0] OFS_PIN2_CFG  = 4'h2;
	localparam logic [3:0] OFS_THRESHOLD = 4'h3;
	localparam logic [3:0] OFS_CHANNEL_ASSESS_MODE  = 4'h4;
	localparam logic [3:0] OFS_STATUS    = 4'h5;

	// pin configuration field positions
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 5;
	localparam int INV_BIT = 6;

	// reset values
	localparam logic [5:0] PIN0_SEL_RST  = 6'h3F;
	localparam logic [5:0] PIN1_SEL_RST  = 6'h2F;
	localparam logic [5:0] PIN2_SEL_RST  = 6'h2F;
	localparam logic [3:0] THR_RST       = 4'h0;
	localparam logic [1:0] CHANNEL_ASSESS_MODE_RST  = 2'h0;

	// select codes
	localparam logic [5:0] SEL_FILL_THRESHOLD_CODE   = 6'h00;
	localparam logic [5:0] SEL_FIFO_PKT   = 6'h01;
	localparam logic [5:0] SEL_OVERFLOW   = 6'h04;
	localparam logic [5:0] SEL_SYNC       = 6'h06;
	localparam logic [5:0] SEL_CRC_PKT    = 6'h07;
	localparam logic [5:0] SEL_CCA        = 6'h09;
	localparam logic [5:0] SEL_LOCK       = 6'h0A;
	localparam logic [5:0] SEL_SER_CLK    = 6'h0B;
	localparam logic [5:0] SEL_SER_DATA   = 6'h0C;
	localparam logic [5:0] SEL_ASYNC_DATA = 6'h0D;
	localparam logic [5:0] SEL_CARRIER    = 6'h0E;
	localparam logic [5:0] SEL_CRC_MATCH  = 6'h0F;
	localparam logic [5:0] SEL_AMP_PD     = 6'h1C;
	localparam logic [5:0] SEL_SLOW_CLK   = 6'h27;
	localparam logic [5:0] SEL_CHIP_RDY   = 6'h29;
	localparam logic [5:0] SEL_HIGH_Z     = 6'h2E;
	localparam logic [5:0] SEL_LOW        = 6'h2F;
	localparam logic [5:0] SEL_DIV192     = 6'h3F;
	localparam logic [5:0] SEL_SLEEP_LIM  = 6'h20;

	// threshold: code n gives 4*(n+1) bytes
	localparam int THR_STEP    = 4;
	localparam int FILL_W      = 7;
	// crystal divide ratio for the pin 0 default
	localparam int XTAL_DIV    = 192;

	typedef enum logic [1:0] {
		CCA_ALWAYS   = 2'b00,
		CCA_RSSI     = 2'b01,
		CCA_NOT_RX   = 2'b10,
		CCA_BOTH     = 2'b11
	} channel_assess_mode_t;

	// receiver status carried into the block
	typedef struct packed {
		logic [6:0] fill_level;
		logic       fifo_empty;
		logic       packet_end;
		logic       overflow;
		logic       flush;
		logic       sync_detect;
		logic       packet_drop;
		logic       crc_good_pkt;
		logic       first_byte_read;
		logic       crc_compare;
		logic       crc_match;
		logic       rssi_above;
		logic       rssi_below;
		logic       receiving;
		logic       radio_idle;
		logic       rx_enter;
		logic       pll_lock;
		logic       serial_clk;
		logic       serial_sync_data;
		logic       async_data;
		logic       amp_powerdown_flag;
		logic       slow_clock_out;
		logic       chip_ready_low;
	} rx_status_t;

endpackage

// [design/crystal_divider.sv]
// divides the crystal-derived core clock into a pin level square wave
`timescale 1ns/1ps
module crystal_divider
	import pin_select_pkg::*;
#(
	parameter int DIV = XTAL_DIV
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	output logic      clk_div
);

	localparam int HALF = DIV / 2;
	localparam int CW   = $clog2(HALF);

	logic [CW-1:0] cnt_q;
	logic          clk_div_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_q     <= '0;
			clk_div_q <= 1'b0;
		end else if (cnt_q == CW'(HALF - 1)) begin
			cnt_q     <= '0;
			clk_div_q <= ~clk_div_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign clk_div = clk_div_q;

	AST_DIV_PERIOD: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cnt_q == CW'(HALF - 1)) |=> clk_div_q != $past(clk_div_q))
		else $error("divider did not toggle after half period");

endmodule

// [design/status_pin_signal_select.sv]
// status pin signal select: routes receiver signals onto three status pins
`timescale 1ns/1ps
module status_pin_signal_select
	import pin_select_pkg::*;
#(
	parameter int NPINS = 3,
	parameter int DIV   = XTAL_DIV
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire rx_status_t        rx_status,
	output logic                   status_pin_zero,
	output logic                   status_pin_one,
	output logic                   status_pin_two,
	output logic      [NPINS-1:0]  status_pin_oe_n
);

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [FILL_W-1:0] thr_bytes(input logic [3:0] code);
		thr_bytes = FILL_W'((int'(code) + 1) * THR_STEP);
	endfunction

	function automatic logic [DATA_W-1:0] cfg_word(input logic [5:0] sel,
		input logic inv);
		cfg_word = {1'b0, inv, sel};
	endfunction

	// sleep level of a pin: pins 0 and 2 follow invert, pin 1 its opposite
	function automatic logic sleep_level(input int idx, input logic inv);
		sleep_level = (idx == 1) ? ~inv : inv;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [5:0]       sel_q [NPINS];
	logic [NPINS-1:0] inv_q;
	logic [3:0]       thr_q;
	channel_assess_mode_t        channel_assess_mode_q;
	logic [DATA_W-1:0] rdata_q;

	logic             fifo_pkt_q;
	logic             overflow_q;
	logic             sync_q;
	logic             crc_pkt_q;
	logic             crc_match_q;
	logic             carrier_q;
	logic [NPINS-1:0] pin_q;
	logic [NPINS-1:0] oe_n_q;

	logic             clk_div;
	logic             at_thr;
	logic             cca;
	logic [63:0]      sig_vec;

	////////////////////////////////////////////////////////////////////////
	// register writes

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sel_q[0] <= PIN0_SEL_RST;
			sel_q[1] <= PIN1_SEL_RST;
			sel_q[2] <= PIN2_SEL_RST;
			inv_q    <= '0;
		end else if (reg_write) begin
			for (int i = 0; i < NPINS; i++) begin
				if (reg_addr == ADDR_W'(i)) begin
					sel_q[i] <= reg_wdata[SEL_MSB:SEL_LSB];
					inv_q[i] <= reg_wdata[INV_BIT];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			thr_q      <= THR_RST;
			channel_assess_mode_q <= channel_assess_mode_t'(CHANNEL_ASSESS_MODE_RST);
		end else if (reg_write) begin
			if (reg_addr == OFS_THRESHOLD)
				thr_q <= reg_wdata[3:0];
			if (reg_addr == OFS_CHANNEL_ASSESS_MODE)
				channel_assess_mode_q <= channel_assess_mode_t'(reg_wdata[1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register reads: data stands the cycle after the strobe only

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (reg_read) begin
			case (reg_addr)
				OFS_PIN0_CFG:  rdata_q <= cfg_word(sel_q[0], inv_q[0]);
				OFS_PIN1_CFG:  rdata_q <= cfg_word(sel_q[1], inv_q[1]);
				OFS_PIN2_CFG:  rdata_q <= cfg_word(sel_q[2], inv_q[2]);
				OFS_THRESHOLD: rdata_q <= {4'h0, thr_q};
				OFS_CHANNEL_ASSESS_MODE:  rdata_q <= {6'h00, channel_assess_mode_q};
				OFS_STATUS:    rdata_q <= {fifo_pkt_q, overflow_q, sync_q,
					crc_pkt_q, crc_match_q, carrier_q, 2'b00};
				default:       rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// event flags; a set in the same cycle as its clear wins, except carrier sense, where radio idle wins over rssi above

	assign at_thr = rx_status.fill_level >= thr_bytes(thr_q);

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			fifo_pkt_q <= 1'b0;
		else if (at_thr || rx_status.packet_end)
			fifo_pkt_q <= 1'b1;
		else if (rx_status.fifo_empty)
			fifo_pkt_q <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			overflow_q <= 1'b0;
		else if (rx_status.overflow)
			overflow_q <= 1'b1;
		else if (rx_status.flush)
			overflow_q <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			sync_q <= 1'b0;
		else if (rx_status.sync_detect)
			sync_q <= 1'b1;
		else if (rx_status.packet_end)
			sync_q <= 1'b0;
		else if (rx_status.packet_drop || rx_status.overflow)
			sync_q <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			crc_pkt_q <= 1'b0;
		else if (rx_status.crc_good_pkt)
			crc_pkt_q <= 1'b1;
		else if (rx_status.first_byte_read)
			crc_pkt_q <= 1'b0;
	end

	// a failed comparison also clears, the flag tracks the last result
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			crc_match_q <= 1'b0;
		else if (rx_status.crc_compare && rx_status.crc_match)
			crc_match_q <= 1'b1;
		else if (rx_status.rx_enter || rx_status.crc_compare)
			crc_match_q <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			carrier_q <= 1'b0;
		else if (rx_status.radio_idle)
			carrier_q <= 1'b0;
		else
			carrier_q <= rx_status.rssi_above;
	end

	////////////////////////////////////////////////////////////////////////
	// channel assessment

	always_comb begin
		case (channel_assess_mode_q)
			CCA_ALWAYS: cca = 1'b1;
			CCA_RSSI:   cca = rx_status.rssi_below;
			CCA_NOT_RX: cca = ~rx_status.receiving;
			CCA_BOTH:   cca = rx_status.rssi_below & ~rx_status.receiving;
			default:    cca = 1'b0;
		endcase
	end

	crystal_divider #(
		.DIV (DIV)
	) u_div (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_div  (clk_div)
	);

	////////////////////////////////////////////////////////////////////////
	// signal table; reserved and omitted codes read as low

	always_comb begin
		sig_vec                 = '0;
		sig_vec[SEL_FILL_THRESHOLD_CODE]   = at_thr;
		sig_vec[SEL_FIFO_PKT]   = fifo_pkt_q;
		sig_vec[SEL_OVERFLOW]   = overflow_q;
		sig_vec[SEL_SYNC]       = sync_q;
		sig_vec[SEL_CRC_PKT]    = crc_pkt_q;
		sig_vec[SEL_CCA]        = cca;
		sig_vec[SEL_LOCK]       = rx_status.pll_lock;
		sig_vec[SEL_SER_CLK]    = rx_status.serial_clk;
		sig_vec[SEL_SER_DATA]   = rx_status.serial_sync_data;
		sig_vec[SEL_ASYNC_DATA] = rx_status.async_data;
		sig_vec[SEL_CARRIER]    = carrier_q;
		sig_vec[SEL_CRC_MATCH]  = crc_match_q;
		sig_vec[SEL_AMP_PD]     = rx_status.amp_powerdown_flag;
		sig_vec[SEL_SLOW_CLK]   = rx_status.slow_clock_out;
		sig_vec[SEL_CHIP_RDY]   = rx_status.chip_ready_low;
		sig_vec[SEL_LOW]        = 1'b0;
		sig_vec[SEL_DIV192]     = clk_div;
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers; registered so decode glitches never reach the pins.
	// clock and data both pass one flop, keeping serial alignment.

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_q  <= '0;
			oe_n_q <= '0;
		end else begin
			for (int i = 0; i < NPINS; i++) begin
				if (sel_q[i] < SEL_SLEEP_LIM && rx_status.chip_ready_low)
					pin_q[i] <= sleep_level(i, inv_q[i]);
				else
					pin_q[i] <= sig_vec[sel_q[i]] ^ inv_q[i];
				oe_n_q[i] <= (sel_q[i] == SEL_HIGH_Z);
			end
		end
	end

	assign status_pin_zero = pin_q[0];
	assign status_pin_one  = pin_q[1];
	assign status_pin_two  = pin_q[2];
	assign status_pin_oe_n = oe_n_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic live0;
	assign live0 = !(sel_q[0] < SEL_SLEEP_LIM && rx_status.chip_ready_low);

	sequence s_sel0(logic [5:0] code);
		sel_q[0] == code && live0;
	endsequence

	// flag up, then a packet end that no new sync word overrides
	sequence s_sync_then_end;
		sync_q ##1 (rx_status.packet_end && !rx_status.sync_detect);
	endsequence

	AST_RESET_DIV192: assert property ($rose(rst_n) |-> sel_q[0] == 6'h3F)
		else $error("pin zero select not at divide default");
	AST_THRESHOLD: assert property (s_sel0(SEL_FILL_THRESHOLD_CODE) |=>
		pin_q[0] == (($past(rx_status.fill_level) >=
		FILL_W'((int'($past(thr_q)) + 1) * 4)) ^ $past(inv_q[0])))
		else $error("threshold pin level wrong");
	AST_FIFO_HOLD: assert property (fifo_pkt_q && !rx_status.fifo_empty
		|=> fifo_pkt_q)
		else $error("fifo packet flag dropped before empty");
	AST_OVERFLOW: assert property (rx_status.overflow |=> overflow_q &&
		(!sync_q || $past(rx_status.sync_detect)))
		else $error("overflow not flagged or sync not cleared");
	AST_SYNC_END: assert property (s_sync_then_end |=> !sync_q)
		else $error("sync flag not cleared at packet end");
	AST_SYNC_DROP: assert property (rx_status.packet_drop &&
		!rx_status.sync_detect |=> !sync_q)
		else $error("sync flag not cleared on drop");
	AST_CRC_READ: assert property (rx_status.first_byte_read &&
		!rx_status.crc_good_pkt |=> !crc_pkt_q)
		else $error("good packet flag not cleared on read");
	AST_CARRIER_IDLE: assert property (rx_status.radio_idle |=> !carrier_q)
		else $error("carrier sense not cleared in idle");
	AST_CRC_ENTER: assert property (rx_status.rx_enter &&
		!rx_status.crc_compare |=> !crc_match_q)
		else $error("checksum match not cleared on receive entry");
	AST_SLEEP_PIN1: assert property (sel_q[1] < SEL_SLEEP_LIM &&
		rx_status.chip_ready_low |=> status_pin_one == !$past(inv_q[1]))
		else $error("pin one sleep level wrong");
	AST_ASYNC_PASS: assert property (s_sel0(SEL_ASYNC_DATA) |=>
		status_pin_zero == ($past(rx_status.async_data) ^ $past(inv_q[0])))
		else $error("async data not passed to pin zero");
	AST_RDATA_ONCE: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data stood beyond its cycle");

endmodule

// [testbench/host_monitor.sv]
// host side model: reads the three status pins as interrupt inputs
`timescale 1ns/1ps
module host_monitor (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] pin_level,
	input  wire logic [2:0] pin_oe_n,
	input  wire logic       irq_clr,
	output logic      [2:0] lock_seen
);
	logic [2:0] wire_lvl;
	logic [2:0] prev_q;
	logic [2:0] irq_q;

	// a released pin falls to the host pull-down
	assign wire_lvl = pin_level & ~pin_oe_n;
	// lock is a latched rising edge or a level held high
	assign lock_seen = irq_q | (wire_lvl & prev_q);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prev_q <= 3'h0;
			irq_q  <= 3'h0;
		end else begin
			prev_q <= wire_lvl;
			irq_q  <= (irq_q | (wire_lvl & ~prev_q)) & {3{~irq_clr}};
		end
	end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the status pin signal select block
`timescale 1ns/1ps
module testbench;
	import pin_select_pkg::*;

	logic              core_clk;
	logic              rst_n;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_write;
	logic              reg_read;
	logic [DATA_W-1:0] reg_rdata;
	rx_status_t        rs;
	logic              pin0;
	logic              pin1;
	logic              pin2;
	logic [2:0]        oe_n;
	logic              irq_clr;
	logic [2:0]        lock_seen;
	logic              last;
	int                err_count;
	int                tests_run;
	int                cyc;
	int                n;
	logic [5:0]        dcode [6] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h1C, 6'h27};
	int                dsrc [6]  = '{10, 11, 12, 13, 14, 15};
	int                ksrc [3]  = '{0, 4, 1};
	logic [3:0]        thr [3]   = '{4'h0, 4'h7, 4'hF};

	// small divide keeps the default clock test short
	status_pin_signal_select #(.NPINS(3), .DIV(4)) uut (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_write       (reg_write),
		.reg_read        (reg_read),
		.reg_rdata       (reg_rdata),
		.rx_status       (rs),
		.status_pin_zero (pin0),
		.status_pin_one  (pin1),
		.status_pin_two  (pin2),
		.status_pin_oe_n (oe_n)
	);

	host_monitor host (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pin_level ({pin2, pin1, pin0}),
		.pin_oe_n  (oe_n),
		.irq_clr   (irq_clr),
		.lock_seen (lock_seen)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard, well above the expected few hundred cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic pins(input logic e);
		#1;
		chk({5'h00, pin2, pin1, pin0}, {5'h00, {3{e}}});
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// only defined codes, never a second divided clock
	task automatic sel_all(input logic [5:0] c, input logic inv);
		wr(OFS_PIN0_CFG, {1'b0, inv, c});
		wr(OFS_PIN1_CFG, {1'b0, inv, c});
		wr(OFS_PIN2_CFG, {1'b0, inv, c});
	endtask

	task automatic set_src(input int k, input logic [6:0] v);
		case (k)
		0: rs.packet_end <= v[0];
		1: rs.overflow <= v[0];
		2: rs.flush <= v[0];
		3: rs.sync_detect <= v[0];
		4: rs.packet_drop <= v[0];
		5: rs.crc_good_pkt <= v[0];
		6: rs.first_byte_read <= v[0];
		7: rs.rx_enter <= v[0];
		8: rs.radio_idle <= v[0];
		9: rs.rssi_above <= v[0];
		10: rs.pll_lock <= v[0];
		11: rs.serial_clk <= v[0];
		12: rs.serial_sync_data <= v[0];
		13: rs.async_data <= v[0];
		14: rs.amp_powerdown_flag <= v[0];
		15: rs.slow_clock_out <= v[0];
		16: rs.fifo_empty <= v[0];
		17: rs.rssi_below <= v[0];
		18: rs.receiving <= v[0];
		19: rs.chip_ready_low <= v[0];
		20: rs.crc_match <= v[0];
		21: rs.crc_compare <= v[0];
		default: rs.fill_level <= v;
		endcase
	endtask

	// level change, pins checked lat cycles later
	task automatic drive(input int k, input logic [6:0] v, input int lat,
			input logic e);
		@(posedge core_clk);
		set_src(k, v);
		repeat (lat) @(posedge core_clk);
		pins(e);
	endtask

	// one-cycle event, flag pins checked two cycles on
	task automatic ev(input int k, input logic e);
		@(posedge core_clk);
		set_src(k, 7'h01);
		@(posedge core_clk);
		set_src(k, 7'h00);
		@(posedge core_clk);
		pins(e);
	endtask

	task automatic clr_irq();
		@(posedge core_clk);
		irq_clr <= 1'b1;
		@(posedge core_clk);
		irq_clr <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		rs = '0;
		rs.fifo_empty = 1'b1;
		irq_clr = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(OFS_PIN0_CFG, {2'b00, PIN0_SEL_RST});
		rd(OFS_PIN1_CFG, {2'b00, PIN1_SEL_RST});
		rd(4'hF, 8'h00);
		n = 0;
		for (int i = 0; i < 9; i++) begin
			@(posedge core_clk);
			#1;
			if (i > 0 && pin0 !== last) n++;
			last = pin0;
		end
		chk(8'(n), 8'h04);
		// overflow flag also shows in the status register
		sel_all(SEL_OVERFLOW, 1'b0);
		ev(1, 1'b1);
		rd(OFS_STATUS, 8'h40);
		drive(16, 7'h01, 2, 1'b1);
		ev(2, 1'b0);
		sel_all(SEL_FILL_THRESHOLD_CODE, 1'b0);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_THRESHOLD, {4'h0, thr[i]});
			drive(22, 7'(4 * (thr[i] + 1) - 1), 1, 1'b0);
			drive(22, 7'(4 * (thr[i] + 1)), 1, 1'b1);
			drive(22, 7'h00, 1, 1'b0);
		end
		sel_all(SEL_FIFO_PKT, 1'b0);
		drive(16, 7'h00, 2, 1'b0);
		ev(0, 1'b1);
		drive(16, 7'h01, 2, 1'b0);
		sel_all(SEL_SYNC, 1'b0);
		for (int i = 0; i < 3; i++) begin
			ev(3, 1'b1);
			ev(ksrc[i], 1'b0);
		end
		sel_all(SEL_CRC_PKT, 1'b0);
		ev(5, 1'b1);
		ev(6, 1'b0);
		sel_all(SEL_CARRIER, 1'b0);
		ev(9, 1'b1);
		drive(9, 7'h01, 2, 1'b1);
		ev(8, 1'b0);
		drive(9, 7'h00, 2, 1'b0);
		sel_all(SEL_CRC_MATCH, 1'b0);
		drive(20, 7'h01, 1, 1'b0);
		ev(21, 1'b1);
		ev(7, 1'b0);
		ev(21, 1'b1);
		drive(20, 7'h00, 2, 1'b1);
		ev(21, 1'b0);
		sel_all(SEL_CCA, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CHANNEL_ASSESS_MODE, 8'(m));
			for (int c = 0; c < 4; c++) begin
				@(posedge core_clk);
				set_src(17, 7'(c & 1));
				drive(18, 7'(c >> 1), 2,
					(!m[0] | c[0]) & (!m[1] | !c[1]));
			end
		end
		for (int i = 0; i < 6; i++) begin
			sel_all(dcode[i], 1'b0);
			drive(dsrc[i], 7'h01, 1, 1'b1);
			drive(dsrc[i], 7'h00, 1, 1'b0);
		end
		sel_all(SEL_LOCK, 1'b0);
		clr_irq();
		drive(10, 7'h01, 1, 1'b1);
		@(posedge core_clk);
		#1;
		chk({5'h00, lock_seen}, 8'h07);
		drive(10, 7'h00, 1, 1'b0);
		#1;
		chk({5'h00, lock_seen}, 8'h07);
		clr_irq();
		@(posedge core_clk);
		#1;
		chk({5'h00, lock_seen}, 8'h00);
		for (int v = 0; v < 2; v++) begin
			sel_all(SEL_ASYNC_DATA, v[0]);
			drive(13, 7'h00, 1, v[0]);
			@(posedge core_clk);
			set_src(19, 7'h01);
			@(posedge core_clk);
			#1;
			chk({5'h00, pin2, pin1, pin0}, {5'h00, v[0], !v[0], v[0]});
			drive(19, 7'h00, 1, v[0]);
		end
		sel_all(SEL_SLOW_CLK, 1'b0);
		drive(19, 7'h01, 1, 1'b0);
		drive(15, 7'h01, 1, 1'b1);
		wr(OFS_PIN1_CFG, {2'b00, SEL_HIGH_Z});
		@(posedge core_clk);
		@(posedge core_clk);
		#1;
		chk({5'h00, oe_n}, 8'h02);
		give_verdict();
	end
endmodule
